//--- mqfifo_pkg.sv
package mqfifo_pkg;

    // ---------------------------------------------
    // Sizes
    // ---------------------------------------------
    localparam int NQ = 4;                    // Queues in quad mode
    localparam int LANE_W = 10;               // One lane of the data bus
    localparam int BW = 2 * LANE_W;           // Per-queue field, wide dual
    localparam int AW_DEF = 15;               // 32768 words per queue
    localparam logic [31:0] OFFSET_RST = 32'h0000_0007; // Almost-flag offset after reset

    // ---------------------------------------------
    // Timing
    // ---------------------------------------------
    localparam int CLK_PERIOD_PS = 4000;      // 250 MHz system clock
    localparam int LINK_HALF_CYC = 10;        // Link clock half period in clk_i cycles
    localparam int RECOVERY_NS = 1000;        // Strap hold after reset release
    localparam int RECOVERY_CYC = (RECOVERY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Binary to gray, widest pointer fits in 32 bits
    function automatic logic [31:0] bin2gray(input logic [31:0] b);
        return b ^ (b >> 1);
    endfunction

    // Gray to binary
    function automatic logic [31:0] gray2bin(input logic [31:0] g);
        logic [31:0] b;
        b = g;
        for (int i = 30; i >= 0; i--)
        begin
            b[i] = b[i + 1] ^ g[i];
        end
        return b;
    endfunction

endpackage

//--- mqfifo_if.sv
`timescale 1ns/100ps
interface mqfifo_if;
    localparam int NQ = mqfifo_pkg::NQ;
    localparam int BW = mqfifo_pkg::BW;

    // Resets and static configuration
    logic master_reset_n;
    logic [NQ-1:0] partial_reset_n;
    logic write_double_rate;
    logic read_double_rate;
    logic flag_timing_select;
    logic dual_mode;
    logic wide_bus;
    // Write ports
    logic [NQ-1:0] wclk;
    logic [NQ-1:0] write_enable_n;
    logic [NQ-1:0] write_select_n;
    logic [NQ*BW-1:0] wdata;
    logic [NQ-1:0] full_flag_n;
    logic [NQ-1:0] almost_full_flag_n;
    // Read ports
    logic [NQ-1:0] rclk;
    logic [NQ-1:0] read_enable_n;
    logic [NQ-1:0] read_select_n;
    logic [NQ*BW-1:0] q_rise;
    logic [NQ*BW-1:0] q_fall;
    logic [NQ-1:0] empty_flag_n;
    logic [NQ-1:0] almost_empty_flag_n;
    // Serial offset port
    logic sclk;
    logic serial_write_strobe_n;
    logic serial_read_strobe_n;
    logic mode_or_serial_input;
    logic serial_out;

    modport dev (
        input master_reset_n, partial_reset_n, write_double_rate, read_double_rate,
        input flag_timing_select, dual_mode, wide_bus,
        input wclk, write_enable_n, write_select_n, wdata,
        output full_flag_n, almost_full_flag_n,
        input rclk, read_enable_n, read_select_n,
        output q_rise, q_fall, empty_flag_n, almost_empty_flag_n,
        input sclk, serial_write_strobe_n, serial_read_strobe_n, mode_or_serial_input,
        output serial_out
    );

    modport host (
        output master_reset_n, partial_reset_n, write_double_rate, read_double_rate,
        output flag_timing_select, dual_mode, wide_bus,
        output wclk, write_enable_n, write_select_n, wdata,
        input full_flag_n, almost_full_flag_n,
        output rclk, read_enable_n, read_select_n,
        input q_rise, q_fall, empty_flag_n, almost_empty_flag_n,
        output sclk, serial_write_strobe_n, serial_read_strobe_n, mode_or_serial_input,
        input serial_out
    );
endinterface

//--- mqfifo_dev.sv
`timescale 1ns/100ps
module mqfifo_dev #(
    parameter int AW = mqfifo_pkg::AW_DEF  // Slot index width, depth is 2**AW; pointers carry one more bit
) (
    // Link side, every port clock comes from the partner
    mqfifo_if.dev bus
);
    localparam int NQ = mqfifo_pkg::NQ;
    localparam int BW = mqfifo_pkg::BW;
    localparam int LW = mqfifo_pkg::LANE_W;
    localparam int DEPTH = 2 ** AW;
    localparam int SW = NQ * 2 * AW;

    // ---------------------------------------------
    // State types
    // ---------------------------------------------
    // Strap capture, one per clock domain
    typedef struct packed {
        logic [1:0] age;     // Link edges seen since reset
        logic [2:0] sy;      // Three-stage pin synchroniser
        logic taken;         // Strap has been captured
        logic fwft;          // Fall-through mode selected
    } mqf_mode_t;

    // Serial offset port
    typedef struct packed {
        logic [SW-1:0] offs; // Almost-empty and almost-full offsets per queue
        logic sout;          // Serial output bit
    } mqf_ser_t;

    // Write domain of one queue
    typedef struct packed {
        logic [AW:0] wbin;   // Write pointer
        logic [AW:0] wgray;  // Gray copy sent to the read side
        logic [AW:0] rg1;    // Read pointer, first sync stage
        logic [AW:0] rg2;    // Read pointer, second sync stage
        logic full;          // Queue full
        logic afull_n;       // Almost full, low when near full
        logic pend;          // Falling half owed to the slot below
        logic [AW-1:0] hidx; // Slot that takes the falling half
    } mqf_wst_t;

    // Read domain of one queue
    typedef struct packed {
        logic [AW:0] rbin;   // Read pointer
        logic [AW:0] rgray;  // Gray copy sent to the write side
        logic [AW:0] wg1;    // Write pointer, first sync stage
        logic [AW:0] wg2;    // Write pointer, second sync stage
        logic has;           // Standard: words held; fall-through: output valid
        logic aempty_n;      // Almost empty, low when near empty
        logic hpend;         // Falling output half owed
        logic [AW-1:0] lidx; // Slot of the word on the output
        logic [BW-1:0] qr;   // Rising-edge output word
    } mqf_rst_t;

    wire mrst = ~bus.master_reset_n;

    // ---------------------------------------------
    // Serial offset loading
    // ---------------------------------------------
    mqf_ser_t s;
    mqf_ser_t next_s;

    // Shift in while write strobe is low; rotate out while read strobe is low
    always_comb
    begin
        next_s = s;
        if (!bus.serial_write_strobe_n)
        begin
            next_s.offs = {s.offs[SW-2:0], bus.mode_or_serial_input};
        end
        else if (!bus.serial_read_strobe_n)
        begin
            next_s.offs = {s.offs[SW-2:0], s.offs[SW-1]};
        end
        next_s.sout = next_s.offs[SW-1];
    end

    // Offsets survive partial resets, only master reset reloads them
    always_ff @(posedge bus.sclk or posedge mrst)
    begin
        if (mrst)
        begin
            s <= '{offs: {(2 * NQ){AW'(mqfifo_pkg::OFFSET_RST)}}, sout: 1'b0};
        end
        else
        begin
            s <= next_s;
        end
    end

    assign bus.serial_out = s.sout;

    // ---------------------------------------------
    // Per-queue logic
    // ---------------------------------------------
    // Each queue runs on its own write and read clock
    for (genvar gq = 0; gq < NQ; gq++)
    begin : g_q
        // Odd queues are held in reset in dual mode
        wire off_q = bus.dual_mode & (gq % 2 == 1);
        wire qrst = mrst | ~bus.partial_reset_n[gq] | off_q;
        wire [BW-1:0] field = bus.wdata[gq * BW +: BW];
        // Narrow lanes keep only the low ten bits
        wire [BW-1:0] din = bus.wide_bus ? field : {{(BW - LW){1'b0}}, field[LW-1:0]};
        wire [AW-1:0] pae_off = s.offs[(2 * gq) * AW +: AW];
        wire [AW-1:0] paf_off = s.offs[(2 * gq + 1) * AW +: AW];

        logic [BW-1:0] mem_r [DEPTH];  // Rising-edge halves
        logic [BW-1:0] mem_f [DEPTH];  // Falling-edge halves
        mqf_mode_t wm, next_wm, rm, next_rm;
        mqf_wst_t w, next_w;
        mqf_rst_t r, next_r;
        logic wr_go;
        logic [BW-1:0] qf;

        // Strap capture on both sides; the pin is held through recovery
        always_comb
        begin
            next_wm = wm;
            next_wm.sy = {wm.sy[1:0], bus.mode_or_serial_input};
            // Reset zeros would agree at once, so wait until all stages hold samples
            if (wm.age != 2'h3)
            begin
                next_wm.age = wm.age + 2'h1;
            end
            else if (!wm.taken && wm.sy[1] == wm.sy[2])
            begin
                next_wm.taken = 1'b1;
                next_wm.fwft = wm.sy[2];
            end
            next_rm = rm;
            next_rm.sy = {rm.sy[1:0], bus.mode_or_serial_input};
            if (rm.age != 2'h3)
            begin
                next_rm.age = rm.age + 2'h1;
            end
            else if (!rm.taken && rm.sy[1] == rm.sy[2])
            begin
                next_rm.taken = 1'b1;
                next_rm.fwft = rm.sy[2];
            end
        end

        // Mode is kept across partial resets
        always_ff @(posedge bus.wclk[gq] or posedge mrst)
        begin
            if (mrst)
            begin
                wm <= '0;
            end
            else
            begin
                wm <= next_wm;
            end
        end

        always_ff @(posedge bus.rclk[gq] or posedge mrst)
        begin
            if (mrst)
            begin
                rm <= '0;
            end
            else
            begin
                rm <= next_rm;
            end
        end

        // Write side: enables count only at the rising edge
        always_comb
        begin
            logic [AW:0] rb;
            logic [AW:0] cnt;
            rb = '0;
            cnt = '0;
            next_w = w;
            wr_go = ~bus.write_enable_n[gq] & ~bus.write_select_n[gq] & ~w.full;
            next_w.wbin = w.wbin + (AW + 1)'(wr_go);
            next_w.wgray = (AW + 1)'(mqfifo_pkg::bin2gray(32'(next_w.wbin)));
            next_w.rg1 = r.rgray;
            next_w.rg2 = w.rg1;
            // Flags move only on this clock, so a stopped clock freezes them
            next_w.full = next_w.wgray == {~w.rg2[AW:AW-1], w.rg2[AW-2:0]};
            rb = (AW + 1)'(mqfifo_pkg::gray2bin(32'(w.rg2)));
            cnt = next_w.wbin - rb;
            next_w.afull_n = ((AW + 1)'(DEPTH) - cnt) > {1'b0, paf_off};
            // Falling half follows a qualified rising edge
            next_w.pend = wr_go & bus.write_double_rate;
            next_w.hidx = w.wbin[AW-1:0];
        end

        always_ff @(posedge bus.wclk[gq] or posedge qrst)
        begin
            if (qrst)
            begin
                w <= '{afull_n: 1'b1, default: '0};
            end
            else
            begin
                w <= next_w;
            end
        end

        // Storage: rising half on the rising edge, falling half a half cycle later
        always_ff @(posedge bus.wclk[gq])
        begin
            if (wr_go)
            begin
                mem_r[w.wbin[AW-1:0]] <= din;
            end
        end

        // A blocked rising edge leaves pend low, so nothing lands here either
        always_ff @(negedge bus.wclk[gq])
        begin
            if (w.pend)
            begin
                mem_f[w.hidx] <= din;
            end
        end

        // Read side: the write pointer needs two edges to cross, the third
        // edge loads the output, and a skew miss costs one more edge
        always_comb
        begin
            logic rd_req;
            logic empty_now;
            logic load;
            logic [AW:0] cnt;
            rd_req = 1'b0;
            empty_now = 1'b0;
            load = 1'b0;
            cnt = '0;
            next_r = r;
            rd_req = ~bus.read_enable_n[gq] & ~bus.read_select_n[gq];
            next_r.wg1 = w.wgray;
            next_r.wg2 = r.wg1;
            empty_now = r.rgray == r.wg2;
            if (rm.fwft)
            begin
                load = ~empty_now & (~r.has | rd_req);
            end
            else
            begin
                load = ~empty_now & rd_req;
            end
            if (load)
            begin
                next_r.qr = mem_r[r.rbin[AW-1:0]];
                next_r.lidx = r.rbin[AW-1:0];
                next_r.rbin = r.rbin + (AW + 1)'(1);
            end
            next_r.hpend = load & bus.read_double_rate;
            next_r.rgray = (AW + 1)'(mqfifo_pkg::bin2gray(32'(next_r.rbin)));
            // Flags move only on this clock, so a stopped clock freezes them
            if (rm.fwft)
            begin
                next_r.has = load | (r.has & ~rd_req);
            end
            else
            begin
                next_r.has = next_r.rgray != next_r.wg2;
            end
            cnt = (AW + 1)'(mqfifo_pkg::gray2bin(32'(next_r.wg2))) - next_r.rbin;
            next_r.aempty_n = cnt > {1'b0, pae_off};
        end

        always_ff @(posedge bus.rclk[gq] or posedge qrst)
        begin
            if (qrst)
            begin
                r <= '0;
            end
            else
            begin
                r <= next_r;
            end
        end

        // Falling output half
        always_ff @(negedge bus.rclk[gq] or posedge qrst)
        begin
            if (qrst)
            begin
                qf <= '0;
            end
            else if (r.hpend)
            begin
                qf <= mem_f[r.lidx];
            end
        end

        // Pin polarity: empty/full flags low when active, ready flags low when ready
        assign bus.q_rise[gq * BW +: BW] = r.qr;
        assign bus.q_fall[gq * BW +: BW] = qf;
        assign bus.empty_flag_n[gq] = rm.fwft ? ~r.has : r.has;
        assign bus.full_flag_n[gq] = wm.fwft ? w.full : ~w.full;
        assign bus.almost_empty_flag_n[gq] = r.aempty_n;
        assign bus.almost_full_flag_n[gq] = w.afull_n;
    end

endmodule // mqfifo_dev

//--- mqfifo_host.sv
`timescale 1ns/100ps
module mqfifo_host #(
    parameter bit FWFT = 1'b0,        // Strap driven during recovery after reset release
    parameter bit WRITE_DOUBLE_RATE = 1'b0,        // Write double rate
    parameter bit READ_DOUBLE_RATE = 1'b0,        // Read double rate
    parameter bit DUAL = 1'b0,        // Two-queue mode
    parameter bit WIDE = 1'b0,        // Twenty-bit lanes in dual mode
    parameter int HALF = mqfifo_pkg::LINK_HALF_CYC,
    parameter int RSR = mqfifo_pkg::RECOVERY_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Write requests, one per queue, word is falling half over rising half
    input wire logic [mqfifo_pkg::NQ-1:0] wr_valid_i,
    input wire logic [2*mqfifo_pkg::NQ*mqfifo_pkg::BW-1:0] wr_data_i,
    output logic [mqfifo_pkg::NQ-1:0] wr_ready_o,
    // Read requests
    input wire logic [mqfifo_pkg::NQ-1:0] rd_req_i,
    output logic [mqfifo_pkg::NQ-1:0] rd_valid_o,
    output logic [2*mqfifo_pkg::NQ*mqfifo_pkg::BW-1:0] rd_data_o,
    output logic busy_o,
    // Link
    mqfifo_if.host bus
);
    localparam int NQ = mqfifo_pkg::NQ;
    localparam int BW = mqfifo_pkg::BW;
    localparam int SV = 2 * NQ + 2 * NQ * BW;  // Synchronised flags and data

    typedef struct packed {
        logic [15:0] cnt;          // Link clock divider
        logic lk;                  // Link clock level
        logic mrst_n;              // Master reset out
        logic [15:0] rec;          // Recovery countdown
        logic bsy;                 // Recovery in progress
        logic msi;                 // Strap / serial data pin
        logic [NQ-1:0] wclk;
        logic [NQ-1:0] rclk;
        logic [NQ-1:0] we_n;
        logic [NQ-1:0] re_n;
        logic [NQ*BW-1:0] wd;      // Data on the pins
        logic [NQ*BW-1:0] hib;     // Falling half waiting for the rising step
        logic [NQ-1:0] pend;       // Standard read issued last cycle
        logic [NQ-1:0] wrr;
        logic [NQ-1:0] rdv;
        logic [2*NQ*BW-1:0] rdd;
        logic [SV-1:0] sa, sb, sc, st; // Pin synchroniser and agreed value
    } mqfh_st_t;

    mqfh_st_t h;
    mqfh_st_t next_h;
    logic [NQ-1:0] act;

    // Odd queues are idle in dual mode
    always_comb
    begin
        for (int q = 0; q < NQ; q++)
        begin
            act[q] = ~(DUAL && (q % 2 == 1));
        end
    end

    // Divider makes the link clock; commands change on its falling step
    always_comb
    begin
        logic [NQ-1:0] ffs;
        logic [NQ-1:0] efs;
        logic fall;
        logic rise;
        logic go;
        logic iss;
        go = 1'b0;
        iss = 1'b0;
        next_h = h;
        next_h.wrr = '0;
        next_h.rdv = '0;
        next_h.mrst_n = 1'b1;
        next_h.sa = {bus.full_flag_n, bus.empty_flag_n, bus.q_fall, bus.q_rise};
        next_h.sb = h.sa;
        next_h.sc = h.sb;
        next_h.st = (h.sb & h.sc) | (h.st & (h.sb | h.sc));
        ffs = h.st[SV-1 -: NQ];
        efs = h.st[SV-NQ-1 -: NQ];
        fall = 1'b0;
        rise = 1'b0;
        if (h.cnt == 16'(HALF - 1))
        begin
            next_h.cnt = '0;
            next_h.lk = ~h.lk;
            fall = h.lk;
            rise = ~h.lk;
        end
        else
        begin
            next_h.cnt = h.cnt + 16'h0001;
        end
        // Pins switch half way between steps, so data set on a step is
        // settled at both pin edges and output halves are synced by the step
        if (h.cnt == 16'(HALF / 2 - 1))
        begin
            next_h.wclk = {NQ{~h.lk}} & act;
            next_h.rclk = {NQ{~h.lk}} & act;
        end
        if (h.rec != '0)
        begin
            next_h.rec = h.rec - 16'h0001;
        end
        next_h.msi = (h.rec != '0) ? FWFT : 1'b0;
        next_h.bsy = next_h.rec != '0;
        for (int q = 0; q < NQ; q++)
        begin
            if (fall)
            begin
                go = act[q] & (h.rec == '0) & wr_valid_i[q] & (FWFT ? ~ffs[q] : ffs[q]);
                // A standard read in flight blocks a second pop while the request stays up
                iss = act[q] & (h.rec == '0) & rd_req_i[q] & (FWFT ? ~efs[q] : efs[q] & ~h.pend[q]);
                next_h.we_n[q] = ~go;
                next_h.wrr[q] = go;
                next_h.wd[q * BW +: BW] = wr_data_i[2 * q * BW +: BW];
                next_h.hib[q * BW +: BW] = wr_data_i[(2 * q + 1) * BW +: BW];
                next_h.re_n[q] = ~iss;
                next_h.pend[q] = iss;
                next_h.rdv[q] = FWFT ? iss : h.pend[q];
                next_h.rdd[2 * q * BW +: 2 * BW] = {h.st[NQ * BW + q * BW +: BW], h.st[q * BW +: BW]};
            end
            else if (rise && WRITE_DOUBLE_RATE)
            begin
                next_h.wd[q * BW +: BW] = h.hib[q * BW +: BW];
            end
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            h <= '{rec: 16'(RSR), bsy: 1'b1, we_n: '1, re_n: '1, default: '0};
        end
        else
        begin
            h <= next_h;
        end
    end

    // Static pins are constants from parameters, except flag_timing_select, which is tied high
    assign bus.master_reset_n = h.mrst_n;
    assign bus.partial_reset_n = {NQ{h.mrst_n}};
    assign bus.write_double_rate = WRITE_DOUBLE_RATE;
    assign bus.read_double_rate = READ_DOUBLE_RATE;
    assign bus.flag_timing_select = 1'b1;
    assign bus.dual_mode = DUAL;
    assign bus.wide_bus = WIDE;
    assign bus.wclk = h.wclk;
    assign bus.rclk = h.rclk;
    assign bus.write_enable_n = h.we_n;
    assign bus.write_select_n = ~act;
    assign bus.read_enable_n = h.re_n;
    assign bus.read_select_n = ~act;
    assign bus.wdata = h.wd;
    assign bus.sclk = 1'b0;
    assign bus.serial_write_strobe_n = 1'b1;
    assign bus.serial_read_strobe_n = 1'b1;
    assign bus.mode_or_serial_input = h.msi;
    assign wr_ready_o = h.wrr;
    assign rd_valid_o = h.rdv;
    assign rd_data_o = h.rdd;
    assign busy_o = h.bsy;

endmodule // mqfifo_host

//--- mqfifo_assertions.sv
`timescale 1ns/100ps
// ---------------------------------------------
// Link checks on queue 0 of the standard pair
// ---------------------------------------------
module mqfifo_assertions (
    // Reset and static straps
    input wire logic master_reset_n,
    input wire logic write_double_rate,
    input wire logic read_double_rate,
    // Link clocks
    input wire logic [3:0] wclk,
    input wire logic [3:0] rclk,
    // Read controls and outputs
    input wire logic [3:0] read_enable_n,
    input wire logic [3:0] read_select_n,
    input wire logic [79:0] q_rise,
    input wire logic [79:0] q_fall,
    // Flags
    input wire logic [3:0] empty_flag_n,
    input wire logic [3:0] full_flag_n,
    input wire logic [3:0] almost_empty_flag_n,
    input wire logic [3:0] almost_full_flag_n
);
    // No pop at this edge: a control is off or the queue is empty
    sequence s_no_read;
        read_enable_n[0] || read_select_n[0] || !empty_flag_n[0];
    endsequence
    property p_rise_held;
        @(posedge rclk[0]) disable iff (!master_reset_n) s_no_read |=> $stable(q_rise[19:0]);
    endproperty
    a_rise_held: assert property (p_rise_held) else $error("rising word moved unasked");
    property p_fall_held;
        @(posedge rclk[0]) disable iff (!master_reset_n) s_no_read |=> $stable(q_fall[19:0]);
    endproperty
    a_fall_held: assert property (p_fall_held) else $error("falling word moved unasked");
    // Straps must never toggle once running
    property p_write_double_rate_fixed;
        @(posedge wclk[0]) disable iff (!master_reset_n) 1'b1 |=> $stable(write_double_rate);
    endproperty
    a_write_double_rate_fixed: assert property (p_write_double_rate_fixed) else $error("write rate strap moved");
    property p_read_double_rate_fixed;
        @(posedge rclk[0]) disable iff (!master_reset_n) 1'b1 |=> $stable(read_double_rate);
    endproperty
    a_read_double_rate_fixed: assert property (p_read_double_rate_fixed) else $error("read rate strap moved");
    // Depth 16 with offset 7: empty and full exclude each other
    property p_flags_apart;
        @(posedge rclk[0]) disable iff (!master_reset_n) !empty_flag_n[0] |-> full_flag_n[0];
    endproperty
    a_flags_apart: assert property (p_flags_apart) else $error("empty and full together");
    property p_empty_near;
        @(posedge rclk[0]) disable iff (!master_reset_n) !empty_flag_n[0] |-> !almost_empty_flag_n[0];
    endproperty
    a_empty_near: assert property (p_empty_near) else $error("empty without almost empty");
    property p_full_near;
        @(posedge wclk[0]) disable iff (!master_reset_n) !full_flag_n[0] |-> !almost_full_flag_n[0];
    endproperty
    a_full_near: assert property (p_full_near) else $error("full without almost full");
    property p_empty_stops;
        @(posedge rclk[0]) disable iff (!master_reset_n) !empty_flag_n[0] ##1 !empty_flag_n[0] |-> $stable(q_rise[19:0]);
    endproperty
    a_empty_stops: assert property (p_empty_stops) else $error("read while empty");
endmodule // mqfifo_assertions

//--- mqfifo_tb.sv
`timescale 1ns/100ps
module mqfifo_tb;
    // ---------------------------------------------
    // User side of both pairs, all driven at time zero
    // ---------------------------------------------
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [3:0] wr_valid [2] = '{default: 4'h0};
    logic [159:0] wr_data [2] = '{default: 160'h0};
    logic [3:0] rd_req [2] = '{default: 4'h0};
    logic [3:0] wr_ready [2];
    logic [3:0] rd_valid [2];
    logic [159:0] rd_data [2];
    logic busy [2];
    int errors = 0;
    int num_checks = 0;
    // Pair 0 standard double rate, pair 1 fall-through single rate
    for (genvar g = 0; g < 2; g++)
    begin : gen_pair
        mqfifo_if bus ();
        mqfifo_host #(.FWFT(g == 1), .WRITE_DOUBLE_RATE(g == 0), .READ_DOUBLE_RATE(g == 0), .DUAL(1'b0), .WIDE(1'b0), .HALF(10), .RSR(80))
        mqfifo_host_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .wr_valid_i(wr_valid[g]), .wr_data_i(wr_data[g]),
            .wr_ready_o(wr_ready[g]), .rd_req_i(rd_req[g]), .rd_valid_o(rd_valid[g]), .rd_data_o(rd_data[g]),
            .busy_o(busy[g]), .bus(bus.host));
        mqfifo_dev #(.AW(4)) mqfifo_dev_inst (.bus(bus.dev));
        if (g == 0)
        begin : gen_chk
            mqfifo_assertions mqfifo_assertions_inst (.master_reset_n(bus.master_reset_n),
                .write_double_rate(bus.write_double_rate), .read_double_rate(bus.read_double_rate),
                .wclk(bus.wclk), .rclk(bus.rclk), .read_enable_n(bus.read_enable_n),
                .read_select_n(bus.read_select_n), .q_rise(bus.q_rise), .q_fall(bus.q_fall),
                .empty_flag_n(bus.empty_flag_n), .full_flag_n(bus.full_flag_n),
                .almost_empty_flag_n(bus.almost_empty_flag_n), .almost_full_flag_n(bus.almost_full_flag_n));
        end
    end
    initial forever #2 clk_i = ~clk_i;
    // ---------------------------------------------
    // Shared tasks
    // ---------------------------------------------
    task automatic chk(input bit ok);
        num_checks++;
        if (!ok)
        begin
            errors++;
            $display("[ERR] %0t compare failed", $time);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Halves differ so a swapped pair shows up; only ten bits per lane in quad mode
    function automatic logic [39:0] word(input int k);
        return {10'h0, ~10'(k), 10'h0, 10'(k)};
    endfunction
    // Offer one word; want says whether it should be taken
    task automatic wr(input int p, input int q, input logic [39:0] d, input bit want);
        bit got;
        got = 1'b0;
        @(negedge clk_i);
        wr_valid[p][q] = 1'b1;
        wr_data[p][q*40+:40] = d;
        for (int i = 0; i < 200 && !got; i++)
        begin
            @(negedge clk_i);
            got = (wr_ready[p][q] === 1'b1);
        end
        wr_valid[p][q] = 1'b0;
        chk(got == want);
        if (want && !got)
            conclude();
    endtask
    // Request one word; single rate compares only the rising lane
    task automatic rd(input int p, input int q, input logic [39:0] exp, input bit want);
        logic [39:0] m;
        bit got;
        m = (p == 0) ? 40'h3FF0_03FF : 40'h0_03FF;
        got = 1'b0;
        @(negedge clk_i);
        rd_req[p][q] = 1'b1;
        for (int i = 0; i < 200 && !got; i++)
        begin
            @(negedge clk_i);
            got = (rd_valid[p][q] === 1'b1);
        end
        rd_req[p][q] = 1'b0;
        chk(got == want && (!got || (rd_data[p][q*40+:40] & m) === (exp & m)));
        if (want && !got)
            conclude();
    endtask
    // ---------------------------------------------
    // Scenarios
    // ---------------------------------------------
    task automatic t_reset_flags();
        chk(gen_pair[0].bus.empty_flag_n === 4'h0 && gen_pair[0].bus.full_flag_n === 4'hF);
        chk(gen_pair[0].bus.almost_empty_flag_n === 4'h0 && gen_pair[0].bus.almost_full_flag_n === 4'hF);
        chk(gen_pair[1].bus.empty_flag_n === 4'hF && gen_pair[1].bus.full_flag_n === 4'h0);
    endtask
    // Fill queue 0 until refused, then drain in order; queue 2 untouched meanwhile
    task automatic t_standard();
        wr(0, 2, 40'h0155_002AA, 1'b1);
        for (int k = 0; k < 16; k++)
            wr(0, 0, word(k), 1'b1);
        wr(0, 0, word(16), 1'b0);
        chk(gen_pair[0].bus.full_flag_n[0] === 1'b0 && gen_pair[0].bus.q_rise[9:0] === 10'h0);
        for (int k = 0; k < 16; k++)
            rd(0, 0, word(k), 1'b1);
        rd(0, 0, 40'h0, 1'b0);
        rd(0, 2, 40'h0155_002AA, 1'b1);
    endtask
    // Head word shows unasked between the third and fourth read edge; later ones wait
    task automatic t_fall_through();
        wr(1, 1, 40'h123, 1'b1);
        repeat (50) @(negedge clk_i);
        chk(gen_pair[1].bus.empty_flag_n[1] === 1'b1);
        repeat (60) @(negedge clk_i);
        chk(gen_pair[1].bus.empty_flag_n[1] === 1'b0 && gen_pair[1].bus.q_rise[29:20] === 10'h123);
        wr(1, 1, 40'h2B4, 1'b1);
        repeat (100) @(negedge clk_i);
        chk(gen_pair[1].bus.q_rise[29:20] === 10'h123);
        rd(1, 1, 40'h123, 1'b1);
        rd(1, 1, 40'h2B4, 1'b1);
        rd(1, 1, 40'h0, 1'b0);
    endtask
    // ---------------------------------------------
    // Main sequence and hang guard
    // ---------------------------------------------
    initial
    begin
        bit up;
        repeat (8) @(negedge clk_i);
        sys_rst_i = 1'b0;
        up = 1'b0;
        @(negedge clk_i);
        for (int i = 0; i < 500 && !up; i++)
        begin
            @(negedge clk_i);
            up = (busy[0] === 1'b0 && busy[1] === 1'b0);
        end
        chk(up);
        if (!up)
            conclude();
        t_reset_flags();
        t_standard();
        t_fall_through();
        conclude();
    end
    initial
    begin
        #200000;
        errors++;
        conclude();
    end
endmodule // mqfifo_tb
